//--- asrc_consts.svh
// Purpose: timing and geometry constants for the async sram host controller
// Assumes: 40 MHz clock, 25 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
`define ASRC_CLK_PERIOD_NS 25
`define ASRC_ADDR_W 16
// access time from select falling, slowest grade
`define ASRC_SEL_ACCESS_NS 55
// strobe falling to device output floating, slowest grade
`define ASRC_STROBE_TO_FLOAT_DELAY_NS 25
// least strobe low time
`define ASRC_STROBE_WIDTH_NS 25
// address setup before the strobe falls
`define ASRC_ADDR_SETUP_NS 5
// address hold after the end of a write
`define ASRC_ADDR_HOLD_NS 5
// read data crosses two flip-flops before the response takes it
`define ASRC_SYNC_STAGES 2
// least times round up
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CNT_W 4
`endif

//--- asrc_pkg.sv
// Purpose: types for the async sram host controller
// Assumes: nothing
// Notes: constants live in asrc_consts.svh
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_RD_WAIT,
    ASRC_WR_SETUP,
    ASRC_WR_FLOAT,
    ASRC_WR_PULSE,
    ASRC_WR_HOLD
  } asrc_state_t;
endpackage

//--- asrc_delay.sv
// Purpose: loadable down counter giving a done flag after n cycles
// Assumes: load and count on one clock
// Notes: done is high while the count is zero
`timescale 1ns/10ps
`include "asrc_consts.svh"
module asrc_delay #(
  parameter int W = `ASRC_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] count;
  assign done = (count == '0);
  always_ff @(posedge clk)
  begin
    if (!resetn)
      count <= '0;
    else if (load)
      count <= value;
    else if (!done)
      count <= count - 1'b1;
  end
endmodule // asrc_delay

//--- asrc_ctrl.sv
// Purpose: host controller driving an async 64k x 1 sram by its pins
// Assumes: separate d and q pins; q sampled through two flip-flops
// Notes:
`timescale 1ns/10ps
`include "asrc_consts.svh"
module asrc_ctrl #(
  parameter int ADDR_W = `ASRC_ADDR_W,
  parameter int CNT_W = `ASRC_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic [ADDR_W-1:0] addr_lines,
  output logic sel_n,
  output logic wstrobe_n,
  output logic d_out,
  output logic d_oe,
  input wire logic q_in
);
  // ==========================================================
  // timing counts
  // the read wait adds the synchroniser stages, so q is sampled a full
  // access time after select falls, whatever the deselect gap was
  localparam logic [CNT_W-1:0] ACC_CYC =
    CNT_W'(`ASRC_CYC(`ASRC_SEL_ACCESS_NS) + `ASRC_SYNC_STAGES);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'(`ASRC_CYC(`ASRC_STROBE_TO_FLOAT_DELAY_NS));
  localparam logic [CNT_W-1:0] WP_CYC =
    CNT_W'(`ASRC_CYC(`ASRC_STROBE_WIDTH_NS));
  localparam logic [CNT_W-1:0] AS_CYC =
    CNT_W'(`ASRC_CYC(`ASRC_ADDR_SETUP_NS));
  localparam logic [CNT_W-1:0] WR_CYC =
    CNT_W'(`ASRC_CYC(`ASRC_ADDR_HOLD_NS));

  // ==========================================================
  // pin synchroniser
  logic q_meta;
  logic q_sync;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      q_meta <= 1'b0;
      q_sync <= 1'b0;
    end
    else
    begin
      q_meta <= q_in;
      q_sync <= q_meta;
    end
  end

  // ==========================================================
  // state and counter
  asrc_pkg::asrc_state_t state;
  asrc_pkg::asrc_state_t next_state;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_done;

  asrc_delay #(.W(CNT_W)) u_delay (
    .clk(clk),
    .resetn(resetn),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  wire logic take_req = (state == asrc_pkg::ASRC_IDLE) && req_valid;
  wire logic rd_finish = (state == asrc_pkg::ASRC_RD_WAIT) && tmr_done;

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = '0;
    case (state)
      asrc_pkg::ASRC_IDLE:
        if (req_valid)
        begin
          tmr_load = 1'b1;
          // address and select move on one edge; access runs from both
          if (req_write)
          begin
            next_state = asrc_pkg::ASRC_WR_SETUP;
            tmr_value = AS_CYC;
          end
          else
          begin
            next_state = asrc_pkg::ASRC_RD_WAIT;
            tmr_value = ACC_CYC;
          end
        end
      asrc_pkg::ASRC_RD_WAIT:
        if (tmr_done)
          next_state = asrc_pkg::ASRC_IDLE;
      asrc_pkg::ASRC_WR_SETUP:
        if (tmr_done)
        begin
          // strobe falls after select: device q floats within this wait
          next_state = asrc_pkg::ASRC_WR_FLOAT;
          tmr_load = 1'b1;
          tmr_value = FLOAT_CYC;
        end
      asrc_pkg::ASRC_WR_FLOAT:
        if (tmr_done)
        begin
          next_state = asrc_pkg::ASRC_WR_PULSE;
          tmr_load = 1'b1;
          tmr_value = WP_CYC;
        end
      asrc_pkg::ASRC_WR_PULSE:
        if (tmr_done)
        begin
          // strobe rises first, ending the write
          next_state = asrc_pkg::ASRC_WR_HOLD;
          tmr_load = 1'b1;
          tmr_value = WR_CYC;
        end
      asrc_pkg::ASRC_WR_HOLD:
        if (tmr_done)
          next_state = asrc_pkg::ASRC_IDLE;
      default:
        next_state = asrc_pkg::ASRC_IDLE;
    endcase
  end

  // ==========================================================
  // pin values
  // select rises only after the strobe, on the same edge that releases data
  wire logic next_sel_n = (next_state == asrc_pkg::ASRC_IDLE);
  wire logic next_wstrobe_n = !((next_state == asrc_pkg::ASRC_WR_FLOAT) ||
    (next_state == asrc_pkg::ASRC_WR_PULSE));
  // data held through strobe rise and beyond for hold time
  wire logic next_d_oe = (next_state == asrc_pkg::ASRC_WR_PULSE) ||
    (next_state == asrc_pkg::ASRC_WR_HOLD);
  wire logic next_req_ready = (next_state == asrc_pkg::ASRC_IDLE) && !take_req;

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      state <= asrc_pkg::ASRC_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // control pins
  // reset lands on the idle levels: deselected, no strobe, d released
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sel_n <= 1'b1;
      wstrobe_n <= 1'b1;
      d_oe <= 1'b0;
    end
    else
    begin
      sel_n <= next_sel_n;
      wstrobe_n <= next_wstrobe_n;
      d_oe <= next_d_oe;
    end
  end

  // ==========================================================
  // address and write data
  // captured once per request and held to the next one or to a reset, which zeroes them;
  // they move only on the edge that lowers select or on a reset edge, never inside an access
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      addr_lines <= '0;
      d_out <= 1'b0;
    end
    else if (take_req)
    begin
      addr_lines <= req_addr;
      d_out <= req_wdata;
    end
  end

  // ==========================================================
  // request and response
  // ready is advisory only: a request is taken whenever the state is idle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 1'b0;
    end
    else
    begin
      req_ready <= next_req_ready;
      rsp_valid <= rd_finish;
      if (rd_finish)
        rsp_rdata <= q_sync;
    end
  end
endmodule // asrc_ctrl

//--- asrc_ctrl_asserts.sv
// Purpose: pin protocol checks for asrc_ctrl
// Assumes: bound to asrc_ctrl ports
// Notes: writes end on the strobe
`timescale 1ns/10ps
module asrc_ctrl_asserts #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [ADDR_W-1:0] addr_lines,
  input wire logic sel_n,
  input wire logic wstrobe_n,
  input wire logic d_out,
  input wire logic d_oe
);
  // ==========
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_strobe_in_sel: assert property (
    $fell(wstrobe_n) |-> !$past(sel_n))
    else $error("strobe fell without select");
  chk_float_first: assert property (
    $fell(wstrobe_n) |-> !d_oe)
    else $error("data driven at strobe fall");
  chk_data_at_rise: assert property (
    $rose(wstrobe_n) |-> d_oe && $stable(d_out))
    else $error("data not held at strobe rise");
  chk_sel_ends_late: assert property (
    $rose(sel_n) |-> $past(wstrobe_n))
    else $error("select rose before strobe");
  chk_drive_in_sel: assert property (
    d_oe |-> !sel_n)
    else $error("data driven while deselected");
  chk_read_no_strobe: assert property (
    req_valid && req_ready && !req_write |=> wstrobe_n [*6])
    else $error("strobe during read");
  chk_addr_steady: assert property (
    !sel_n && !$past(sel_n) |-> $stable(addr_lines))
    else $error("address moved while selected");
  cover property ($rose(rsp_valid));
  cover property ($rose(wstrobe_n));
  cover property (req_valid && req_ready && req_write);
endmodule // asrc_ctrl_asserts
bind asrc_ctrl asrc_ctrl_asserts #(.ADDR_W(ADDR_W)) chk (.clk, .resetn,
  .req_valid, .req_write, .req_ready, .rsp_valid, .addr_lines, .sel_n,
  .wstrobe_n, .d_out, .d_oe);

//--- asrc_sram_model.sv
// Purpose: behavioural 64k x 1 async memory
// Assumes: t_acc in ns, set by the bench
// Notes: floating q toggles every ns so early samples fail
`timescale 1ns/10ps
module asrc_sram_model (
  input wire logic [15:0] addr_lines,
  input wire logic sel_n,
  input wire logic wstrobe_n,
  input wire logic d_out,
  input wire logic d_oe,
  output logic q_in
);
  // ==========
  // array
  logic mem [0:65535];
  realtime t_chg = 0;
  int t_acc = 55;
  // access time runs from the last change of address or control
  always @(addr_lines or sel_n or wstrobe_n)
    t_chg = $realtime;
  // undriven data is stored inverted, so a missed drive shows up
  always @(posedge wstrobe_n or posedge sel_n)
    if (!sel_n || !wstrobe_n)
      mem[addr_lines] = d_oe ? d_out : ~d_out;
  // one process owns q, so it has a single driver
  initial
  begin
    q_in = 1'h0;
    forever
    begin
      #1;
      if (sel_n || !wstrobe_n)
        q_in = ~q_in;
      else if ($realtime - t_chg >= t_acc)
        q_in = mem[addr_lines];
      else
        q_in = ~mem[addr_lines];
    end
  end
endmodule // asrc_sram_model

//--- asrc_ctrl_tb.sv
// Purpose: self-checking bench for asrc_ctrl
// Assumes: memory model on the far side
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module asrc_ctrl_tb;
  logic clk = 0, resetn = 0, req_valid = 0, req_write = 0, req_wdata = 0;
  logic [15:0] req_addr = 16'h0000, addr_lines;
  logic req_ready, rsp_valid, rsp_rdata, sel_n, wstrobe_n, d_out, d_oe, q_in;
  logic [15:0] a [4] = '{16'h0000, 16'hffff, 16'h5a5a, 16'h5a5a};
  logic d [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  int mismatches = 0, n_compared = 0;
  asrc_ctrl uut (.clk, .resetn, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .addr_lines, .sel_n, .wstrobe_n,
    .d_out, .d_oe, .q_in);
  asrc_sram_model mdl (.addr_lines, .sel_n, .wstrobe_n, .d_out, .d_oe, .q_in);
  initial forever #12.5 clk = ~clk;
  // ==========
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] ad, input logic wd,
    input logic exp);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'h1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check(16'({req_ready, sel_n}), 16'h0003);
    req_valid = 1'h1;
    req_write = w;
    req_addr = ad;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'h0;
    check(addr_lines, ad);
    n = 0;
    while (!w && rsp_valid !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!w)
      check({rsp_valid, rsp_rdata}, {1'h1, exp});
  endtask
  task automatic t_rw;
    for (int i = 0; i < 4; i++) xfer(1'h1, a[i], d[i], 1'h0);
    for (int i = 0; i < 4; i++) if (i != 2) xfer(1'h0, a[i], 1'h0, d[i]);
    $display("t_rw done");
  endtask
  task automatic t_slow;
    mdl.t_acc = 55;
    xfer(1'h1, 16'ha5a5, 1'h1, 1'h0);
    repeat (100) @(negedge clk);
    xfer(1'h0, 16'ha5a5, 1'h0, 1'h1);
    xfer(1'h0, 16'h0000, 1'h0, 1'h1);
    $display("t_slow done");
  endtask
  // reset in the middle of a write, with the strobe low
  task automatic t_reset;
    xfer(1'h1, 16'h1234, 1'h1, 1'h0);
    repeat (3) @(negedge clk);
    resetn = 1'h0;
    repeat (4) @(negedge clk);
    check(16'({sel_n, wstrobe_n, d_oe}), 16'h0006);
    resetn = 1'h1;
    xfer(1'h1, 16'h4321, 1'h0, 1'h0);
    xfer(1'h0, 16'h4321, 1'h0, 1'h0);
    $display("t_reset done");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    mdl.t_acc = 10;
    repeat (16) @(negedge clk);
    check(16'({sel_n, wstrobe_n, d_oe}), 16'h0006);
    resetn = 1'h1;
    t_rw;
    t_slow;
    t_reset;
    give_verdict;
  end
  initial
  begin
    #50000;
    mismatches++;
    give_verdict;
  end
endmodule // asrc_ctrl_tb
